// ==== hdl/fer_pkg.sv ====
// shared constants, types and the 5b/4b lookup of the fast ethernet receive path
// assumes one line bit per clk edge from the equaliser front end
package fer_pkg;
	localparam int CLK_HZ = 25_000_000;
	localparam int CLK_NS = 40;
	localparam int CLK_PER_US = CLK_HZ / 1_000_000;
	localparam int HOLD_US = 722;
	localparam int HOLD_CYC = HOLD_US * CLK_PER_US;
	localparam int LINK_US = 395;
	localparam int LINK_CYC = LINK_US * CLK_PER_US;
	// pulse filter on signal detect, short enough for data, long enough for link pulses
	localparam int SD_QUAL_NS = 400;
	localparam int SD_QUAL_CYC = (SD_QUAL_NS + CLK_NS - 1) / CLK_NS;
	localparam int CG_W = 5;
	localparam int SYNC_IDLES = 12;
	localparam int SYNC_BITS = SYNC_IDLES * CG_W;
	localparam int IDLE_BITS = 58;
	localparam int RUN_W = 7;
	localparam int LFSR_W = 11;
	localparam int LFSR_TAP_A = 10;
	localparam int LFSR_TAP_B = 8;
	localparam int FC_W = 16;
	localparam logic [4:0] CG_IDLE = 5'h1f;
	localparam logic [4:0] CG_T = 5'h0d;
	localparam logic [4:0] CG_R = 5'h07;
	localparam logic [9:0] CG_JK = 10'h311;
	localparam logic [2:0] JK_WAIT = 3'h6;
	localparam logic [2:0] PH_LAST = 3'h4;
	localparam logic [3:0] NIB_PRE = 4'h5;
	localparam logic [3:0] NIB_BAD = 4'he;

	typedef struct packed {
		logic [3:0] rxd;
		logic stb;
		logic dv;
		logic er;
		logic crs;
	} fer_mii_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CHK = 2'b01,
		ST_DATA = 2'b10,
		ST_BAD = 2'b11
	} fer_state_t;

	// returns {valid, nibble}; control and violation codes come back invalid
	function automatic logic [4:0] fer_dec5(input logic [4:0] cg);
		case (cg)
			5'h1e: return 5'h10;
			5'h09: return 5'h11;
			5'h14: return 5'h12;
			5'h15: return 5'h13;
			5'h0a: return 5'h14;
			5'h0b: return 5'h15;
			5'h0e: return 5'h16;
			5'h0f: return 5'h17;
			5'h12: return 5'h18;
			5'h13: return 5'h19;
			5'h16: return 5'h1a;
			5'h17: return 5'h1b;
			5'h1a: return 5'h1c;
			5'h1b: return 5'h1d;
			5'h1c: return 5'h1e;
			5'h1d: return 5'h1f;
			default: return 5'h00;
		endcase
	endfunction
endpackage

// ==== hdl/fer_descrambler.sv ====
// serial descrambler with idle-based acquisition and hold timer
// assumes nrz bits arrive one per clk; en low holds it in reset
`timescale 1ns/1ps
`default_nettype none
module fer_descrambler
	import fer_pkg::*;
#(
	parameter int HOLD = HOLD_CYC
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic en,
	input wire logic bypass,
	input wire logic sd_bit,
	output logic out_bit,
	output logic locked
);
	localparam int HW = $clog2(HOLD + 1);
	logic [LFSR_W-1:0] lfsr_r, lfsr_nxt;
	logic [RUN_W-1:0] run_r, run_nxt;
	logic [HW-1:0] hold_r, hold_nxt;
	logic locked_r, locked_nxt, out_r, out_nxt, n, ud, reload;

	always_comb
	begin
		n = lfsr_r[LFSR_TAP_A] ^ lfsr_r[LFSR_TAP_B]; // [RULE21]
		ud = sd_bit ^ n; // [RULE3]
		lfsr_nxt = lfsr_r;
		run_nxt = run_r;
		hold_nxt = hold_r;
		locked_nxt = locked_r;
		reload = 1'b0;
		if (!en)
		begin
			lfsr_nxt = '0;
			run_nxt = '0;
			hold_nxt = '0;
			locked_nxt = 1'b0;
		end
		else if (!locked_r)
		begin
			// idle assumed: descrambled one means sequence bit is the inverted line bit
			lfsr_nxt = {lfsr_r[LFSR_W-2:0], ~sd_bit};
			run_nxt = (~sd_bit == n) ? run_r + 1'b1 : '0;
			if (run_r == RUN_W'(SYNC_BITS - 1) && ~sd_bit == n) // [RULE4]
			begin
				locked_nxt = 1'b1;
				run_nxt = '0;
				hold_nxt = HW'(HOLD); // [RULE5]
			end
		end
		else
		begin
			lfsr_nxt = {lfsr_r[LFSR_W-2:0], n};
			run_nxt = ud ? run_r + 1'b1 : '0;
			reload = ud && run_r == RUN_W'(IDLE_BITS - 1);
			if (reload)
			begin
				hold_nxt = HW'(HOLD); // [RULE6]
				run_nxt = '0;
			end
			else if (hold_r == '0)
			begin
				locked_nxt = 1'b0; // [RULE7]
				lfsr_nxt = '0;
				run_nxt = '0;
			end
			else
				hold_nxt = hold_r - 1'b1;
		end
		// bypass hands the raw nrz stream to the aligner
		out_nxt = bypass ? sd_bit : (locked_r ? ud : 1'b1); // [RULE8]
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			lfsr_r <= '0;
			run_r <= '0;
			hold_r <= '0;
			locked_r <= 1'b0;
			out_r <= 1'b1;
		end
		else
		begin
			lfsr_r <= lfsr_nxt;
			run_r <= run_nxt;
			hold_r <= hold_nxt;
			locked_r <= locked_nxt;
			out_r <= out_nxt;
		end
	end

	assign out_bit = out_r;
	assign locked = locked_r;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_sync_after_idles: assert property ($rose(locked_r) |-> $past(run_r) == RUN_W'(SYNC_BITS - 1)) // [RULE4]
		else $error("lock without twelve idle groups");
	a_hold_expiry_drop: assert property (en && locked_r && hold_r == '0 && !reload |=> !locked_r) // [RULE7]
		else $error("lock kept after hold expiry");
	a_descr_xor_out: assert property (en && locked_r && !bypass |=> out_r == $past(ud)) // [RULE3]
		else $error("descrambled bit not line xor sequence");
endmodule
`default_nettype wire

// ==== hdl/fer_link_mon.sv ====
// signal detect qualifier and link integrity monitor
// assumes sd_raw comes from the analog detector, asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module fer_link_mon
	import fer_pkg::*;
#(
	parameter int LINK = LINK_CYC
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic sd_raw,
	output logic sig_det,
	output logic link_up
);
	localparam int LW = $clog2(LINK + 1);
	localparam int QW = $clog2(SD_QUAL_CYC + 1);
	logic sd_s1, sd_s2, sd_r, sd_nxt, up_r, up_nxt;
	logic [QW-1:0] q_r, q_nxt;
	logic [LW-1:0] l_r, l_nxt;

	always_comb
	begin
		// link pulses are far shorter than the filter and never reach sig_det
		q_nxt = !sd_s2 ? '0 : (q_r == QW'(SD_QUAL_CYC) ? q_r : q_r + 1'b1); // [RULE14]
		sd_nxt = sd_s2 && q_r == QW'(SD_QUAL_CYC);
		l_nxt = !sd_r ? '0 : (l_r == LW'(LINK) ? l_r : l_r + 1'b1);
		up_nxt = sd_r && l_r == LW'(LINK); // [RULE13]
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sd_s1 <= 1'b0;
			sd_s2 <= 1'b0;
			q_r <= '0;
			sd_r <= 1'b0;
			l_r <= '0;
			up_r <= 1'b0;
		end
		else
		begin
			sd_s1 <= sd_raw;
			sd_s2 <= sd_s1;
			q_r <= q_nxt;
			sd_r <= sd_nxt;
			l_r <= l_nxt;
			up_r <= up_nxt;
		end
	end

	assign sig_det = sd_r;
	assign link_up = up_r;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_link_after_stable: assert property ($rose(up_r) |-> $past(l_r) == LW'(LINK) && $past(sd_r)) // [RULE13]
		else $error("link up before signal detect stable");
	a_sd_pulse_reject: assert property ($rose(sd_r) |-> $past(sd_s2, 1) && $past(sd_s2, 2)) // [RULE14]
		else $error("signal detect on short pulse");
endmodule
`default_nettype wire

// ==== hdl/fer_rx_pcs.sv ====
// 100 Mb/s receive pcs: mlt3 to nrz, descramble, align, 5b/4b decode, bad ssd
// assumes mlt3_lvl carries one equalised line level per clk, asynchronous to clk
// Contract
// (RULE1) convert mlt3 to nrzi, then nrzi to nrz before descrambling
// (RULE2) deserialize bit stream into 5-bit symbols for the receive state machine
// (RULE3) descramble by xoring each line bit with local sequence
// (RULE4) lock after 12 consecutive idle groups descrambling to ones
// (RULE5) start 722 us hold timer on lock
// (RULE6) reload hold timer on 58 idle bit times within interval
// (RULE7) hold timer expiry drops lock and restarts acquisition
// (RULE8) aligner takes descrambler output or raw nrz when bypassed
// (RULE9) lock code-group boundary after start delimiter pair 11000 10001
// (RULE10) present preamble nibbles 0101 0101 in place of start pair
// (RULE11) translate each following code-group to a nibble by lookup
// (RULE12) stop decoding on end delimiter or two idle groups
// (RULE13) link up only after signal detect valid 395 us
// (RULE14) link pulses never assert signal detect
// (RULE15) idle to non-idle without start pair is bad start delimiter
// (RULE16) on bad start, error and 1110 per group until two idles
// (RULE17) each bad start adds exactly one to false carrier counter
// (RULE18) after bad start, two idles drop error and carrier
// (RULE19) end delimiter is 01101 then 00111
// (RULE20) control groups inside data decode invalid with error
// (RULE21) sequence from closed loop 11-bit lfsr
// (RULE22) sixteen-entry data mapping, other codes invalid
`timescale 1ns/1ps
`default_nettype none
module fer_rx_pcs
	import fer_pkg::*;
#(
	parameter int HOLD = HOLD_CYC,
	parameter int LINK = LINK_CYC
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic [1:0] mlt3_lvl,
	input wire logic sig_det_raw,
	input wire logic scr_bypass,
	output fer_mii_t mii_rx,
	output logic [FC_W-1:0] false_carrier_event_counter,
	output logic sig_det,
	output logic link_up,
	output logic scr_locked
);
	logic [1:0] lvl_s1, lvl_s2, lvl_prev_r;
	logic byp_s1, byp_s2;
	logic nrzi_r, nrzi_nxt, nrzi_d_r, nrz_r, nrz_nxt;
	logic dscr_bit, rx_en;
	fer_state_t state_r, state_nxt;
	logic [9:0] win_r, win_nxt;
	logic [2:0] cnt_r, cnt_nxt, ph_r, ph_nxt;
	logic pre2_r, pre2_nxt, prev_t_r, prev_t_nxt, prev_i_r, prev_i_nxt;
	fer_mii_t mii_r, mii_nxt;
	logic [FC_W-1:0] fc_r, fc_nxt;
	logic [4:0] cg, dec;
	logic grp_done, jk_ok;

	// line front end: each mlt3 level change is a one in nrz
	always_comb
	begin
		nrzi_nxt = nrzi_r ^ (lvl_s2 != lvl_prev_r); // [RULE1]
		nrz_nxt = nrzi_r ^ nrzi_d_r; // [RULE1]
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			lvl_s1 <= 2'h0;
			lvl_s2 <= 2'h0;
			lvl_prev_r <= 2'h0;
			byp_s1 <= 1'b0;
			byp_s2 <= 1'b0;
			nrzi_r <= 1'b0;
			nrzi_d_r <= 1'b0;
			nrz_r <= 1'b0;
		end
		else
		begin
			lvl_s1 <= mlt3_lvl;
			lvl_s2 <= lvl_s1;
			lvl_prev_r <= lvl_s2;
			byp_s1 <= scr_bypass;
			byp_s2 <= byp_s1;
			nrzi_r <= nrzi_nxt;
			nrzi_d_r <= nrzi_r;
			nrz_r <= nrz_nxt;
		end
	end

	fer_link_mon #(
		.LINK(LINK)
	) u_link (
		.clk(clk),
		.rst(rst),
		.sd_raw(sig_det_raw),
		.sig_det(sig_det),
		.link_up(link_up)
	);

	fer_descrambler #(
		.HOLD(HOLD)
	) u_dscr (
		.clk(clk),
		.rst(rst),
		.en(link_up),
		.bypass(byp_s2),
		.sd_bit(nrz_r),
		.out_bit(dscr_bit),
		.locked(scr_locked)
	);

	// receive runs only with link up and a locked (or bypassed) descrambler
	assign rx_en = link_up && (scr_locked || byp_s2); // [RULE13]

	always_comb
	begin
		win_nxt = {win_r[8:0], dscr_bit}; // [RULE2]
		cg = win_nxt[4:0];
		dec = fer_dec5(cg); // [RULE11] [RULE22]
		grp_done = ph_r == PH_LAST;
		jk_ok = win_nxt == CG_JK;
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		ph_nxt = grp_done ? 3'h0 : ph_r + 3'h1; // [RULE2]
		pre2_nxt = 1'b0;
		prev_t_nxt = prev_t_r;
		prev_i_nxt = prev_i_r;
		fc_nxt = fc_r;
		mii_nxt = mii_r;
		mii_nxt.stb = 1'b0;
		case (state_r)
			ST_IDLE:
			begin
				mii_nxt.dv = 1'b0;
				mii_nxt.er = 1'b0;
				mii_nxt.crs = 1'b0;
				// first zero after idle is the third bit of a good start group
				if (!dscr_bit)
				begin
					state_nxt = ST_CHK;
					cnt_nxt = JK_WAIT;
					mii_nxt.crs = 1'b1;
				end
			end
			ST_CHK:
			begin
				if (cnt_r != 3'h0)
					cnt_nxt = cnt_r - 3'h1;
				else if (jk_ok)
				begin
					state_nxt = ST_DATA; // [RULE9]
					ph_nxt = 3'h0; // [RULE9]
					mii_nxt.stb = 1'b1;
					mii_nxt.rxd = NIB_PRE; // [RULE10]
					mii_nxt.dv = 1'b1;
					pre2_nxt = 1'b1;
					prev_t_nxt = 1'b0;
					prev_i_nxt = 1'b0;
				end
				else
				begin
					state_nxt = ST_BAD; // [RULE15]
					ph_nxt = 3'h0;
					fc_nxt = fc_r + 1'b1; // [RULE17]
					mii_nxt.stb = 1'b1;
					mii_nxt.rxd = NIB_BAD; // [RULE16]
					mii_nxt.er = 1'b1;
					prev_i_nxt = 1'b0;
				end
			end
			ST_DATA:
			begin
				if (pre2_r)
				begin
					mii_nxt.stb = 1'b1;
					mii_nxt.rxd = NIB_PRE; // [RULE10]
					mii_nxt.er = 1'b0;
				end
				if (grp_done)
				begin
					if ((prev_t_r && cg == CG_R) || (prev_i_r && cg == CG_IDLE)) // [RULE12] [RULE19]
					begin
						state_nxt = ST_IDLE;
						mii_nxt.dv = 1'b0;
						mii_nxt.er = 1'b0;
						mii_nxt.crs = 1'b0;
					end
					else if (cg == CG_T || cg == CG_IDLE)
					begin
						// held back one group: may be first half of a terminator
						prev_t_nxt = cg == CG_T;
						prev_i_nxt = cg == CG_IDLE;
					end
					else
					begin
						mii_nxt.stb = 1'b1;
						mii_nxt.rxd = dec[4] ? dec[3:0] : NIB_BAD;
						// lone terminator or idle, or J/K/H, inside data is an error
						mii_nxt.er = !dec[4] || prev_t_r || prev_i_r; // [RULE20]
						prev_t_nxt = 1'b0;
						prev_i_nxt = 1'b0;
					end
				end
			end
			ST_BAD:
			begin
				if (grp_done)
				begin
					if (prev_i_r && cg == CG_IDLE)
					begin
						state_nxt = ST_IDLE; // [RULE18]
						mii_nxt.er = 1'b0;
						mii_nxt.crs = 1'b0;
					end
					else
					begin
						mii_nxt.stb = 1'b1;
						mii_nxt.rxd = NIB_BAD; // [RULE16]
						mii_nxt.er = 1'b1;
					end
					prev_i_nxt = cg == CG_IDLE;
				end
			end
			default:
				state_nxt = ST_IDLE;
		endcase
		if (!rx_en)
		begin
			state_nxt = ST_IDLE;
			mii_nxt = '0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_r <= ST_IDLE;
			win_r <= 10'h3ff;
			cnt_r <= 3'h0;
			ph_r <= 3'h0;
			pre2_r <= 1'b0;
			prev_t_r <= 1'b0;
			prev_i_r <= 1'b0;
			fc_r <= '0;
			mii_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			win_r <= win_nxt;
			cnt_r <= cnt_nxt;
			ph_r <= ph_nxt;
			pre2_r <= pre2_nxt;
			prev_t_r <= prev_t_nxt;
			prev_i_r <= prev_i_nxt;
			fc_r <= fc_nxt;
			mii_r <= mii_nxt;
		end
	end

	assign mii_rx = mii_r;
	assign false_carrier_event_counter = fc_r;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_bad_ssd_count: assert property (rx_en && state_r == ST_CHK && cnt_r == 3'h0 && !jk_ok |=> fc_r == $past(fc_r) + 1'b1 && state_r == ST_BAD) // [RULE17]
		else $error("bad start not counted once");
	a_bad_nibble_out: assert property (state_r == ST_BAD && mii_r.stb |-> mii_r.rxd == NIB_BAD && mii_r.er && mii_r.crs) // [RULE16]
		else $error("bad start group not 1110 with error");
	a_preamble_pair: assert property (rx_en && state_r == ST_CHK && cnt_r == 3'h0 && jk_ok |=> mii_r.stb && mii_r.rxd == NIB_PRE ##1 mii_r.stb && mii_r.rxd == NIB_PRE) // [RULE10]
		else $error("start pair not replaced by preamble");
	a_idle_quiet: assert property (state_r == ST_IDLE |-> !mii_r.er && !mii_r.dv && !mii_r.crs) // [RULE18]
		else $error("error or carrier left after idles");
	c_good_frame: cover property (state_r == ST_DATA ##1 state_r == ST_IDLE);
	c_bad_ssd: cover property (state_r == ST_CHK ##1 state_r == ST_BAD);
	c_bad_recover: cover property (state_r == ST_BAD ##1 state_r == ST_IDLE);
endmodule
`default_nettype wire

// ==== bench/fer_line_tx.sv ====
// line-side transmitter model: scrambles, nrzi and mlt3 codes queued groups
// assumes the bench pushes 5-bit groups into q; idles fill every gap
`timescale 1ns/1ps
`default_nettype none
module fer_line_tx (
	input wire logic clk,
	input wire logic scr_on,
	output logic [1:0] mlt3_lvl
);
	logic [4:0] q[$];
	logic [4:0] cur = 5'h1f;
	logic [10:0] s = 11'h5a1;
	logic [1:0] st = 2'h0;
	logic n;
	logic b;
	int ph = 0;
	initial mlt3_lvl = 2'h0;
	// the line never pauses, so an empty queue means idle groups
	always @(posedge clk)
	begin
		if (ph == 0)
			cur = (q.size() != 0) ? q.pop_front() : 5'h1f;
		n = s[10] ^ s[8];
		s = {s[9:0], n};
		b = cur[4 - ph] ^ (scr_on & n);
		st = st + {1'b0, b};
		ph = (ph == 4) ? 0 : ph + 1;
		mlt3_lvl <= #1 st[0] ? (st[1] ? 2'h3 : 2'h1) : 2'h0;
	end
endmodule
`default_nettype wire

// ==== bench/fer_rx_pcs_tb_top.sv ====
// self-checking bench of the receive pcs against a queue model of the frames
// assumes the line model in fer_line_tx and short HOLD and LINK counts
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module fer_rx_pcs_tb_top
	import fer_pkg::*;
;
	localparam int HOLD_T = 300;
	localparam int LINK_T = 50;
	logic clk = 0;
	logic rst = 1;
	logic sd_raw = 0;
	logic byp = 0;
	logic scr_on = 1;
	logic [1:0] lvl;
	fer_mii_t rx;
	logic [FC_W-1:0] fc;
	logic [FC_W-1:0] fc0;
	logic sig_det;
	logic link_up;
	logic locked;
	logic [4:0] got[$];
	logic [4:0] exp_q[$];
	logic [4:0] enc [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
	logic [4:0] ctl [7] = '{5'h1f, 5'h0d, 5'h18, 5'h11, 5'h07, 5'h00, 5'h04};
	int miscompares = 0;
	int samples_checked = 0;
	int cyc = 0;
	int k;
	int lost;
	integer seed = 32'h3bce;

	initial forever #20 clk = ~clk;

	fer_line_tx partner_u (.clk(clk), .scr_on(scr_on), .mlt3_lvl(lvl));

	fer_rx_pcs #(.HOLD(HOLD_T), .LINK(LINK_T)) dut_u (
		.clk(clk), .rst(rst), .mlt3_lvl(lvl), .sig_det_raw(sd_raw), .scr_bypass(byp),
		.mii_rx(rx), .false_carrier_event_counter(fc), .sig_det(sig_det),
		.link_up(link_up), .scr_locked(locked));

	// capture mid-cycle: stb is launched on the rising edge, sampling there would race it
	always @(negedge clk)
	begin
		if (rx.stb === 1'b1)
			got.push_back({rx.er, rx.rxd});
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			results();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic send(input logic [4:0] g);
		partner_u.q.push_back(g);
	endtask

	task automatic drain(input int extra);
		for (k = 0; k < 2000 && partner_u.q.size() != 0; k++)
			tick(1);
		tick(extra);
	endtask

	// a held T or idle merges with the next group into one error nibble
	task automatic frame(input int n, input int at, input logic [4:0] cg);
		logic [3:0] d;
		got.delete();
		exp_q.delete();
		send(5'h18);
		send(5'h11);
		exp_q.push_back({1'b0, NIB_PRE});
		exp_q.push_back({1'b0, NIB_PRE});
		for (int i = 0; i < n; i++)
		begin
			d = (i < 16) ? i[3:0] : 4'($random(seed));
			if (i == at)
			begin
				send(cg);
				exp_q.push_back({1'b1, NIB_BAD});
				if (cg == CG_IDLE || cg == CG_T)
				begin
					send(enc[d]);
					continue;
				end
			end
			send(enc[d]);
			exp_q.push_back({1'b0, d});
		end
		send(CG_T);
		send(CG_R);
		repeat (20) send(CG_IDLE);
		drain(10);
		`CHK(got.size(), exp_q.size())
		foreach (exp_q[i])
			if (exp_q[i][4]) `CHK(got[i][4], 1'b1)
			else `CHK(got[i], exp_q[i])
		`CHK({rx.dv, rx.crs}, 2'h0)
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		tick(16);
		rst = 0;
		`CHK({rx, fc, sig_det, link_up, locked}, 27'h0)
		sd_raw = 1;
		tick(3);
		sd_raw = 0;
		tick(20);
		`CHK(sig_det, 1'b0)
		sd_raw = 1;
		tick(40);
		`CHK(link_up, 1'b0)
		for (k = 0; k < 100 && link_up !== 1'b1; k++)
			tick(1);
		`CHK(link_up, 1'b1)
		for (k = 0; k < 400 && locked !== 1'b1; k++)
			tick(1);
		`CHK(locked, 1'b1)
		lost = 0;
		repeat (HOLD_T * 3)
		begin
			tick(1);
			if (locked !== 1'b1)
				lost++;
		end
		`CHK(lost, 0)
		frame(20, 99, CG_IDLE);
		foreach (ctl[j])
			frame(18, 6, ctl[j]);
		repeat (2)
		begin
			fc0 = fc;
			got.delete();
			send(5'h0a);
			send(5'h0b);
			send(5'h0e);
			send(5'h1c);
			repeat (20) send(CG_IDLE);
			drain(10);
			`CHK(fc, fc0 + 16'h1)
			`CHK(got.size() > 0, 1'b1)
			foreach (got[i])
				`CHK(got[i], {1'b1, NIB_BAD})
			`CHK({rx.er, rx.crs, rx.dv}, 3'h0)
		end
		// no idles for longer than the hold time: lock must go
		send(5'h18);
		send(5'h11);
		repeat (80) send(enc[0]);
		for (k = 0; k < 500 && locked !== 1'b0; k++)
			tick(1);
		`CHK(locked, 1'b0)
		tick(10);
		`CHK(rx, 8'h0)
		repeat (30) send(CG_IDLE);
		drain(10);
		`CHK(locked, 1'b1)
		byp = 1;
		scr_on = 0;
		repeat (20) send(CG_IDLE);
		drain(10);
		frame(20, 99, CG_IDLE);
		results();
	end
endmodule
`default_nettype wire
